// ---- hw/srlc_pkg.sv ----
// Constants for the switch routing and link configuration block.
// Assumes one switch clock; register numbers are node configuration indices.
package srlc_pkg;
   // Register numbers
   localparam logic [7:0] A_NODE_ID = 8'h05;
   localparam logic [7:0] A_USER    = 8'h0A;
   localparam logic [7:0] A_DIR_LO  = 8'h0C;
   localparam logic [7:0] A_DIR_HI  = 8'h0D;
   localparam logic [7:0] A_RSV_A   = 8'h10;
   localparam logic [7:0] A_RSV_B   = 8'h11;
   localparam logic [7:0] A_DBG     = 8'h1F;
   localparam logic [7:0] A_LSTAT   = 8'h20;
   localparam logic [7:0] A_PSTAT   = 8'h40;
   localparam logic [7:0] A_LCFG    = 8'h80;
   // Link configuration fields
   localparam int B_EN    = 31;
   localparam int B_WIDE  = 30;
   localparam int B_ERR   = 27;
   localparam int B_GRANT = 26;
   localparam int B_CRED  = 25;
   localparam int B_GREET = 24;
   localparam int B_RXRST = 23;
   localparam int SG_LO   = 11;
   localparam int TG_LO   = 0;
   localparam int GAP_W   = 11;
   // Link status fields
   localparam int TYPE_LO = 24;
   localparam int DEST_LO = 16;
   localparam int DIR_LO  = 8;
   localparam int NET_LO  = 4;
   localparam int B_JUNK  = 2;
   localparam int B_DBUSY = 1;
   localparam int B_SBUSY = 0;
   // Source target type codes
   localparam logic [1:0] TT_SWITCH = 2'h0;
   localparam logic [1:0] TT_PROC   = 2'h1;
   localparam logic [1:0] TT_CTRL   = 2'h2;
   localparam logic [1:0] TT_UNDEF  = 2'h3;
   // User code and debug source fields
   localparam int UC_LO   = 18;
   localparam int DBG_RSV = 4;
   localparam logic [1:0] DBG_FIRST  = 2'h1;
   localparam logic [1:0] DBG_SECOND = 2'h2;
   // Token framing: pad, control flag, byte
   localparam int TOK_W   = 8;
   localparam int FRAME_W = 12;
   localparam int CTL_BIT = 8;
   localparam logic [2:0] PAD_ZERO = 3'h0;
   localparam logic [7:0] CT_GREET  = 8'h01;
   localparam logic [7:0] CT_CREDIT = 8'h02;
   localparam logic [2:0] SYMS_NARROW = 3'h6;
   localparam logic [2:0] SYMS_WIDE   = 3'h3;
   localparam logic [2:0] SYM_ONE     = 3'h1;
   localparam logic [GAP_W-1:0] GAP_ONE = 11'h001;
   localparam int NARROW_B = 2;
   localparam int WIDE_B   = 4;
   localparam int FIFO_D   = 32;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_SYM  = 3'b010,
      TX_GAP  = 3'b100
   } srlc_tx_t;
endpackage : srlc_pkg

// ---- hw/srlc_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides.
// Depth must be a power of two; pointers wrap by overflow.
module srlc_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                rdy;
   } srlc_fifo_st_t;

   srlc_fifo_st_t q;
   srlc_fifo_st_t next_q;
   logic          push;
   logic          pop;

   assign in_ready  = q.rdy;
   assign out_valid = (q.cnt != '0);
   assign out_data  = q.mem[q.rp];

   always_comb begin
      next_q = q;
      push   = in_valid && (q.cnt != FULL);
      pop    = out_ready && (q.cnt != '0);
      if (push) begin
         next_q.mem[q.wp] = in_data;
         next_q.wp        = q.wp + 1'b1;
      end
      if (pop) begin
         next_q.rp = q.rp + 1'b1;
      end
      if (push && !pop) begin
         next_q.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         next_q.cnt = q.cnt - 1'b1;
      end
      next_q.rdy = (next_q.cnt != FULL);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= next_q;
      end
   end
endmodule : srlc_fifo

// ---- hw/srlc_top.sv ----
// Switch node configuration: routing table, link status and link setup,
// plus the transmit/receive engine of external link 0.
// Assumes the fabric drives per-link status levels and one switch clock.
// Function
// - Lower routing register holds eight directions for mismatches in bits 7..0.
// - Outgoing direction comes from entry of the highest mismatching id bit.
// - Each entry is 4 bits RW, reset zero, dimension n at 4n+3:4n.
// - Upper routing register holds directions for bits 15..8, dimension 8 lowest.
// - Debug source bit 0 marks first core, bit 1 second core.
// - Link status bits 25:24 report source target type code.
// - Link status bits 23:16 show destination link while in use.
// - External link status bits 11:8 hold RW direction, reset zero.
// - Link status bits 5:4 hold RW network number, reset zero.
// - Status bit 2 junk, bit 1 destination busy, bit 0 source busy.
// - Processor link status at 0x40..0x47, same fields, no direction.
// - Config bit 31 enables the link and steers pin multiplexing.
// - Config bit 30 selects 2-wire or 5-wire mode, reset zero.
// - Config bit 27 flags receive overflow or illegal token.
// - Bit 26 shows credit granted, bit 25 credit held; reset zero.
// - Writing bit 24 clears own credit and sends a greeting token.
// - Writing bit 23 resets the receiver to await a new token.
// - Idle gap between symbols is at least field 21:11 plus one.
// - Idle gap between tokens is at least field 10:0 plus one.
// - User code register returns OTP code and identification code.
// - Local node identifier is 16 bits RW, reset zero.
module srlc_top
   import srlc_pkg::*;
#(
   parameter int          NLINK   = 8,
   parameter int          NPLINK  = 8,
   parameter int          DEPTH   = srlc_pkg::FIFO_D,
   // Arbitrary neutral identification value
   parameter logic [17:0] ID_CODE = 18'h00000
) (
   // Clock, reset, enable
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   // Node configuration access
   input  wire logic                   cfg_wr,
   input  wire logic                   cfg_rd,
   input  wire logic [7:0]             cfg_addr,
   input  wire logic [31:0]            cfg_wdata,
   output logic [31:0]                 cfg_rdata,
   output logic                        cfg_rvalid,
   // Fabric status of external links
   input  wire logic [NLINK-1:0][1:0]  lk_type,
   input  wire logic [NLINK-1:0][7:0]  lk_dest,
   input  wire logic [NLINK-1:0]       lk_junk,
   input  wire logic [NLINK-1:0]       lk_dbusy,
   input  wire logic [NLINK-1:0]       lk_sbusy,
   // Fabric status of processor links
   input  wire logic [NPLINK-1:0][1:0] pl_type,
   input  wire logic [NPLINK-1:0][7:0] pl_dest,
   input  wire logic [NPLINK-1:0]      pl_junk,
   input  wire logic [NPLINK-1:0]      pl_dbusy,
   input  wire logic [NPLINK-1:0]      pl_sbusy,
   // Debug and user code
   input  wire logic                   global_debug_event,
   input  wire logic                   dbg_from_second_core,
   input  wire logic [13:0]            otp_user_code,
   // Route lookup
   input  wire logic                   route_req,
   input  wire logic [15:0]            route_dest,
   output logic                        route_valid,
   output logic                        route_local,
   output logic [3:0]                  route_dir,
   // Link pin control
   output logic [NLINK-1:0]            link_enable,
   output logic [NLINK-1:0]            link_wide,
   // Transmit data in
   input  wire logic                   tx_in_valid,
   input  wire logic [TOK_W-1:0]       tx_in_data,
   output logic                        tx_in_ready,
   // Link symbols out
   output logic [WIDE_B-1:0]           tx_sym,
   output logic                        tx_sym_valid,
   // Link symbols in
   input  wire logic [WIDE_B-1:0]      rx_sym,
   input  wire logic                   rx_sym_valid,
   // Received data out
   output logic                        rx_tok_valid,
   output logic [TOK_W-1:0]            rx_tok_data,
   input  wire logic                   rx_tok_ready
);

   typedef struct packed {
      logic [15:0]                    node_id;
      logic [31:0]                    dir_lo;
      logic [31:0]                    dir_hi;
      logic [1:0]                     rsv_a;
      logic [1:0]                     rsv_b;
      logic [2:0]                     dbg;
      logic [NLINK-1:0][3:0]          l_dir;
      logic [NLINK-1:0][1:0]          l_net;
      logic [NPLINK-1:0][1:0]         p_net;
      logic [NLINK-1:0]               en;
      logic [NLINK-1:0]               wide;
      logic [NLINK-1:0][GAP_W-1:0]    sgap;
      logic [NLINK-1:0][GAP_W-1:0]    tgap;
      logic                           err;
      logic                           grant;
      logic                           credit;
      logic                           greet_pend;
      logic                           grant_pend;
      srlc_tx_t                       tx_st;
      logic [FRAME_W-1:0]             tx_sh;
      logic [2:0]                     tx_left;
      logic [GAP_W-1:0]               tx_cnt;
      logic [FRAME_W-1:0]             rx_sh;
      logic [2:0]                     rx_cnt;
      logic [WIDE_B-1:0]              tx_sym;
      logic                           tx_sym_valid;
      logic                           rx_tok_valid;
      logic [TOK_W-1:0]               rx_tok_data;
      logic                           route_valid;
      logic                           route_local;
      logic [3:0]                     route_dir;
      logic [31:0]                    cfg_rdata;
      logic                           cfg_rvalid;
   } srlc_st_t;

   srlc_st_t         q;
   srlc_st_t         next_q;
   logic             take;
   logic             fifo_valid;
   logic [TOK_W-1:0] fifo_data;
   logic [31:0]      rd;
   logic [FRAME_W-1:0] rx_new;
   logic [4:0]       hit;
   logic [63:0]      dirs;

   // Highest set bit of the mismatch, with a found flag on top
   function automatic logic [4:0] msb_mismatch(input logic [15:0] diff);
      logic [4:0] r;
      r = '0;
      for (int b = 0; b < 16; b++) begin
         if (diff[b]) begin
            r = {1'b1, 4'(b)};
         end
      end
      return r;
   endfunction : msb_mismatch

   // Register number of entry i in a per-link bank
   function automatic logic is_entry(input logic [7:0] addr,
                                     input logic [7:0] base, input int i);
      return addr == (base + 8'(i));
   endfunction : is_entry

   srlc_fifo #(
      .W (TOK_W),
      .D (DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (tx_in_valid),
      .in_data   (tx_in_data),
      .in_ready  (tx_in_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (take)
   );

   assign cfg_rdata    = q.cfg_rdata;
   assign cfg_rvalid   = q.cfg_rvalid;
   assign route_valid  = q.route_valid;
   assign route_local  = q.route_local;
   assign route_dir    = q.route_dir;
   assign link_enable  = q.en;
   assign link_wide    = q.wide;
   assign tx_sym       = q.tx_sym;
   assign tx_sym_valid = q.tx_sym_valid;
   assign rx_tok_valid = q.rx_tok_valid;
   assign rx_tok_data  = q.rx_tok_data;

   always_comb begin
      next_q              = q;
      take                = 1'b0;
      rd                  = '0;
      rx_new              = '0;
      hit                 = '0;
      dirs                = {q.dir_hi, q.dir_lo};
      next_q.cfg_rvalid   = 1'b0;
      next_q.route_valid  = 1'b0;
      next_q.tx_sym_valid = 1'b0;
      if (rx_tok_ready) begin
         next_q.rx_tok_valid = 1'b0;
      end

      // Register writes
      if (cfg_wr) begin
         case (cfg_addr)
            A_NODE_ID: next_q.node_id = cfg_wdata[15:0];
            A_DIR_LO:  next_q.dir_lo = cfg_wdata;
            A_DIR_HI:  next_q.dir_hi = cfg_wdata;
            A_RSV_A:   next_q.rsv_a = cfg_wdata[1:0];
            A_RSV_B:   next_q.rsv_b = cfg_wdata[1:0];
            A_DBG:     next_q.dbg = {cfg_wdata[DBG_RSV], cfg_wdata[1:0]};
            default: ;
         endcase
         for (int i = 0; i < NLINK; i++) begin
            if (is_entry(cfg_addr, A_LSTAT, i)) begin
               next_q.l_dir[i] = cfg_wdata[DIR_LO +: 4];
               next_q.l_net[i] = cfg_wdata[NET_LO +: 2];
            end
            if (is_entry(cfg_addr, A_LCFG, i)) begin
               next_q.en[i]   = cfg_wdata[B_EN];
               next_q.wide[i] = cfg_wdata[B_WIDE];
               next_q.sgap[i] = cfg_wdata[SG_LO +: GAP_W];
               next_q.tgap[i] = cfg_wdata[TG_LO +: GAP_W];
            end
         end
         for (int i = 0; i < NPLINK; i++) begin
            if (is_entry(cfg_addr, A_PSTAT, i)) begin
               next_q.p_net[i] = cfg_wdata[NET_LO +: 2];
            end
         end
         if (cfg_addr == A_LCFG) begin
            if (cfg_wdata[B_GREET]) begin
               next_q.credit     = 1'b0;
               next_q.greet_pend = 1'b1;
            end
            if (cfg_wdata[B_RXRST]) begin
               next_q.rx_cnt = '0;
               next_q.rx_sh  = '0;
               next_q.err    = 1'b0;
            end
         end
      end

      // event wins over a same-cycle write
      if (global_debug_event) begin
         next_q.dbg[1:0] = dbg_from_second_core ? DBG_SECOND : DBG_FIRST;
      end

      // Register reads
      case (cfg_addr)
         A_NODE_ID: rd[15:0] = q.node_id;
         A_USER:    rd = {otp_user_code, ID_CODE};
         A_DIR_LO:  rd = q.dir_lo;
         A_DIR_HI:  rd = q.dir_hi;
         A_RSV_A:   rd[1:0] = q.rsv_a;
         A_RSV_B:   rd[1:0] = q.rsv_b;
         A_DBG:     rd[DBG_RSV:0] = {q.dbg[2], 2'h0, q.dbg[1:0]};
         default: ;
      endcase
      for (int i = 0; i < NLINK; i++) begin
         if (is_entry(cfg_addr, A_LSTAT, i)) begin
            rd[TYPE_LO +: 2] = lk_type[i];
            rd[DEST_LO +: 8] = lk_dest[i];
            rd[DIR_LO +: 4]  = q.l_dir[i];
            rd[NET_LO +: 2]  = q.l_net[i];
            rd[B_JUNK]       = lk_junk[i];
            rd[B_DBUSY]      = lk_dbusy[i];
            rd[B_SBUSY]      = lk_sbusy[i];
         end
         if (is_entry(cfg_addr, A_LCFG, i)) begin
            rd[B_EN]            = q.en[i];
            rd[B_WIDE]          = q.wide[i];
            rd[SG_LO +: GAP_W]  = q.sgap[i];
            rd[TG_LO +: GAP_W]  = q.tgap[i];
         end
      end
      if (cfg_addr == A_LCFG) begin
         rd[B_ERR]   = q.err;
         rd[B_GRANT] = q.grant;
         rd[B_CRED]  = q.credit;
      end
      for (int i = 0; i < NPLINK; i++) begin
         if (is_entry(cfg_addr, A_PSTAT, i)) begin
            rd[TYPE_LO +: 2] = pl_type[i];
            rd[DEST_LO +: 8] = pl_dest[i];
            rd[NET_LO +: 2]  = q.p_net[i];
            rd[B_JUNK]       = pl_junk[i];
            rd[B_DBUSY]      = pl_dbusy[i];
            rd[B_SBUSY]      = pl_sbusy[i];
         end
      end
      if (cfg_rd) begin
         next_q.cfg_rvalid = 1'b1;
         next_q.cfg_rdata  = rd;
      end

      // highest mismatching bit picks the entry
      if (route_req) begin
         hit                = msb_mismatch(route_dest ^ q.node_id);
         next_q.route_valid = 1'b1;
         next_q.route_local = !hit[4];
         next_q.route_dir   = hit[4] ? dirs[{hit[3:0], 2'h0} +: 4] : '0;
      end

      // Receiver; disabled link ignores symbols
      if (q.en[0] && rx_sym_valid) begin
         rx_new = q.wide[0] ? {q.rx_sh[FRAME_W-WIDE_B-1:0], rx_sym}
                            : {q.rx_sh[FRAME_W-NARROW_B-1:0], rx_sym[NARROW_B-1:0]};
         next_q.rx_sh  = rx_new;
         next_q.rx_cnt = q.rx_cnt + SYM_ONE;
         if (q.rx_cnt + SYM_ONE == (q.wide[0] ? SYMS_WIDE : SYMS_NARROW)) begin
            next_q.rx_cnt = '0;
            // bad framing or unknown control code
            if (rx_new[FRAME_W-1:CTL_BIT+1] != PAD_ZERO) begin
               next_q.err = 1'b1;
            end else if (rx_new[CTL_BIT]) begin
               if (rx_new[TOK_W-1:0] == CT_GREET) begin
                  next_q.grant_pend = 1'b1;
               end else if (rx_new[TOK_W-1:0] == CT_CREDIT) begin
                  // credit set beats a same-cycle clear
                  next_q.credit = 1'b1;
               end else begin
                  next_q.err = 1'b1;
               end
            end else if (q.rx_tok_valid && !rx_tok_ready) begin
               next_q.err = 1'b1;
            end else begin
               next_q.rx_tok_valid = 1'b1;
               next_q.rx_tok_data  = rx_new[TOK_W-1:0];
            end
         end
      end

      // Transmitter
      case (q.tx_st)
         TX_IDLE: begin
            next_q.tx_left = q.wide[0] ? SYMS_WIDE : SYMS_NARROW;
            if (q.en[0]) begin
               if (q.greet_pend) begin
                  next_q.greet_pend = 1'b0;
                  next_q.tx_sh      = {PAD_ZERO, 1'b1, CT_GREET};
                  next_q.tx_st      = TX_SYM;
               end else if (q.grant_pend) begin
                  next_q.grant_pend = 1'b0;
                  next_q.grant      = 1'b1;
                  next_q.tx_sh      = {PAD_ZERO, 1'b1, CT_CREDIT};
                  next_q.tx_st      = TX_SYM;
               end else if (q.credit && fifo_valid) begin
                  take         = 1'b1;
                  next_q.tx_sh = {PAD_ZERO, 1'b0, fifo_data};
                  next_q.tx_st = TX_SYM;
               end
            end
         end
         TX_SYM: begin
            next_q.tx_sym_valid = q.en[0];
            next_q.tx_left      = q.tx_left - SYM_ONE;
            next_q.tx_st        = TX_GAP;
            if (q.wide[0]) begin
               next_q.tx_sym = q.tx_sh[FRAME_W-1 -: WIDE_B];
               next_q.tx_sh  = q.tx_sh << WIDE_B;
            end else begin
               next_q.tx_sym = {2'h0, q.tx_sh[FRAME_W-1 -: NARROW_B]};
               next_q.tx_sh  = q.tx_sh << NARROW_B;
            end
            next_q.tx_cnt = (q.tx_left == SYM_ONE) ? q.tgap[0] : q.sgap[0];
         end
         TX_GAP: begin
            if (q.tx_cnt == '0) begin
               next_q.tx_st = (q.tx_left == '0) ? TX_IDLE : TX_SYM;
            end else begin
               next_q.tx_cnt = q.tx_cnt - GAP_ONE;
            end
         end
         default: next_q.tx_st = TX_IDLE;
      endcase
      // disabling aborts the token in flight
      if (!q.en[0]) begin
         next_q.tx_st = TX_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q       <= '0;
         q.tx_st <= TX_IDLE;
      end else if (ce) begin
         q <= next_q;
      end
   end
endmodule : srlc_top

// ---- testbench/srlc_top_properties.sv ----
// Port-level properties of the routing and link configuration block.
// Assumes ce is held high; sees only the top module's ports.
module srlc_top_properties
   import srlc_pkg::*;
#(
   parameter int NLINK = 8
) (
   // Clock and reset
   input wire logic              clk, rst,
   // Register access
   input wire logic              cfg_wr, cfg_rd, cfg_rvalid,
   input wire logic [7:0]        cfg_addr,
   input wire logic [31:0]       cfg_wdata,
   // Route lookup
   input wire logic              route_req, route_valid, route_local,
   input wire logic [15:0]       route_dest,
   input wire logic [3:0]        route_dir,
   // Link side
   input wire logic [NLINK-1:0]  link_enable, link_wide,
   input wire logic [WIDE_B-1:0] tx_sym,
   input wire logic              tx_sym_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow of the node id, for local hits
   logic [15:0] nid;
   always_ff @(posedge clk) begin
      if (rst) nid <= '0;
      else if (cfg_wr && cfg_addr == A_NODE_ID) nid <= cfg_wdata[15:0];
   end
   AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read not answered");
   AST_RD_PULSE: assert property (!cfg_rd |=> !cfg_rvalid)
      else $error("read answer without read");
   AST_ROUTE_ANSWER: assert property (route_req |=> route_valid)
      else $error("lookup not answered");
   AST_ROUTE_PULSE: assert property (!route_req |=> !route_valid)
      else $error("lookup answer without request");
   AST_LOCAL_HIT: assert property (route_req && route_dest == nid |=> route_local && route_dir == 4'h0)
      else $error("matching id not local");
   AST_MISMATCH: assert property (route_req && route_dest != nid |=> !route_local)
      else $error("mismatching id taken local");
   AST_EN_CFG: assert property (cfg_wr && cfg_addr == A_LCFG |=> ##1 link_enable[0] == $past(cfg_wdata[B_EN], 2))
      else $error("enable pin not following setup");
   AST_WIDE_CFG: assert property (cfg_wr && cfg_addr == A_LCFG |=> ##1 link_wide[0] == $past(cfg_wdata[B_WIDE], 2))
      else $error("width pin not following setup");
   AST_DIS_QUIET: assert property (!link_enable[0] [*2] |-> !tx_sym_valid)
      else $error("symbol sent on disabled link");
   AST_SYM_GAP: assert property (tx_sym_valid |=> !tx_sym_valid)
      else $error("symbols without idle gap");
   AST_NARROW: assert property (tx_sym_valid && !link_wide[0] |-> tx_sym[3:2] == 2'h0)
      else $error("upper wires used in narrow mode");
   cover property (route_valid && route_local);
   cover property (tx_sym_valid && link_wide[0]);
   cover property (cfg_rd && cfg_addr == A_LCFG);
endmodule : srlc_top_properties

bind srlc_top srlc_top_properties #(.NLINK(NLINK)) chk_u (.*);

// ---- testbench/srlc_remote.sv ----
// Remote switch end of external link 0.
// Assumes symbols MSB first, one valid pulse per symbol.
module srlc_remote
   import srlc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              wide,
   input  wire logic [WIDE_B-1:0] tx_sym,
   input  wire logic              tx_sym_valid,
   output logic [WIDE_B-1:0]      rx_sym,
   output logic                   rx_sym_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [FRAME_W-1:0] sh, got[$];
   int n = 0, idle = 0, min_gap = 999, tok_gap = 0;
   logic reply = 0;
   initial begin
      rx_sym = 4'h0;
      rx_sym_valid = 0;
   end
   task automatic send(input logic [FRAME_W-1:0] f);
      for (int i = 0; i < (wide ? 3 : 6); i++) begin
         @(negedge clk);
         rx_sym = wide ? f[11-4*i -: 4] : {2'h0, f[11-2*i -: 2]};
         rx_sym_valid = 1;
         @(negedge clk);
         rx_sym_valid = 0;
         // Released wire must not keep its value
         rx_sym = ~rx_sym;
      end
   endtask : send
   always @(posedge clk) begin
      if (!tx_sym_valid) idle++;
      else begin
         if (n > 0 && idle < min_gap) min_gap = idle;
         if (n == 0) tok_gap = idle;
         idle = 0;
         sh = wide ? {sh[7:0], tx_sym} : {sh[9:0], tx_sym[1:0]};
         n++;
         if (n == (wide ? 3 : 6)) begin
            n = 0;
            got.push_back(sh);
            if (sh == {PAD_ZERO, 1'b1, CT_GREET}) reply = 1;
         end
      end
   end
   always @(negedge clk) begin
      if (reply) begin
         reply = 0;
         send({PAD_ZERO, 1'b1, CT_CREDIT});
      end
   end
endmodule : srlc_remote

// ---- testbench/tb_srlc_top.sv ----
// Bench for the routing and link configuration block.
// Drives inputs at falling edges; remote link end in srlc_remote.
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR %0t got %h want %h", $time, (a), (e)); end end
module tb_srlc_top
   import srlc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, ce = 1, cfg_wr = 0, cfg_rd = 0, cfg_rvalid, route_req = 0;
   logic [7:0] cfg_addr = 0, tx_in_data = 0, rx_tok_data, link_enable, link_wide;
   logic [31:0] cfg_wdata = 0, cfg_rdata;
   logic [7:0][1:0] lk_type = 0, pl_type = 0;
   logic [7:0][7:0] lk_dest = 0, pl_dest = 0;
   logic [7:0] lk_junk = 0, lk_dbusy = 0, lk_sbusy = 0, pl_junk = 0, pl_dbusy = 0, pl_sbusy = 0;
   logic global_debug_event = 0, dbg_from_second_core = 0, route_valid, route_local;
   logic [13:0] otp_user_code = 14'h2A5;
   logic [15:0] route_dest = 0;
   logic [3:0] route_dir, tx_sym, rx_sym;
   logic tx_in_valid = 0, tx_in_ready, tx_sym_valid, rx_sym_valid, rx_tok_valid;
   logic rx_tok_ready = 0;
   int fail_count = 0, tests_run = 0, cyc = 0;
   srlc_top dut_u (.clk, .rst, .ce, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
      .cfg_rvalid, .lk_type, .lk_dest, .lk_junk, .lk_dbusy, .lk_sbusy, .pl_type, .pl_dest,
      .pl_junk, .pl_dbusy, .pl_sbusy, .global_debug_event, .dbg_from_second_core,
      .otp_user_code, .route_req, .route_dest, .route_valid, .route_local, .route_dir,
      .link_enable, .link_wide, .tx_in_valid, .tx_in_data, .tx_in_ready, .tx_sym,
      .tx_sym_valid, .rx_sym, .rx_sym_valid, .rx_tok_valid, .rx_tok_data, .rx_tok_ready);
   srlc_remote far_u (.clk, .wide(link_wide[0]), .tx_sym, .tx_sym_valid, .rx_sym,
      .rx_sym_valid);
   always #2 clk = ~clk;
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
      @(negedge clk);
      cfg_wr = 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(negedge clk);
      {cfg_rd, cfg_addr} = {1'b1, a};
      @(negedge clk);
      cfg_rd = 0;
      `CHK(cfg_rvalid, 1'b1)
      `CHK(cfg_rdata, e)
   endtask : rd
   task automatic push(input logic [7:0] b);
      @(negedge clk);
      {tx_in_valid, tx_in_data} = {1'b1, b};
      @(negedge clk);
      tx_in_valid = 0;
   endtask : push
   // Bounded wait for the remote end to collect tokens
   task automatic wait_tok(input int n);
      for (int i = 0; i < 3000 && far_u.got.size() < n; i++) @(posedge clk);
   endtask : wait_tok
   initial begin
      repeat (6) @(negedge clk);
      rst = 0;
      rd(A_DIR_LO, 0);
      rd(A_LCFG, 0);
      rd(8'h03, 0);
      wr(A_DIR_LO, 32'h76543210);
      wr(A_DIR_HI, 32'hFEDCBA98);
      wr(A_USER, '1);
      rd(A_USER, {14'h2A5, 18'h0});
      rd(A_DIR_HI, 32'hFEDCBA98);
      wr(A_NODE_ID, 32'h1234);
      rd(A_NODE_ID, 32'h1234);
      for (int k = 0; k < 17; k++) begin
         @(negedge clk);
         route_req = 1;
         route_dest = (k == 16) ? 16'h1234 : 16'h1234 ^ 16'((32'h2 << k) - 1);
         @(negedge clk);
         route_req = 0;
         `CHK(route_local, k == 16)
         `CHK(route_dir, (k == 16) ? 4'h0 : 4'(k))
      end
      wr(A_LSTAT + 8'h3, '1);
      wr(A_PSTAT + 8'h7, '1);
      for (int t = 0; t < 4; t++) begin
         @(negedge clk);
         {lk_type[3], lk_dest[3], lk_junk[3], lk_sbusy[3]} = {2'(t), 8'h5A, t[0], 1'b1};
         {pl_type[7], pl_dest[7], pl_dbusy[7]} = {2'(t), 8'hC3, 1'b1};
         rd(A_LSTAT + 8'h3, {6'h0, 2'(t), 8'h5A, 8'h0F, 5'h06, t[0], 2'h1});
         rd(A_PSTAT + 8'h7, {6'h0, 2'(t), 8'hC3, 8'h00, 8'h32});
      end
      for (int s = 0; s < 2; s++) begin
         @(negedge clk);
         {global_debug_event, dbg_from_second_core} = {1'b1, s[0]};
         @(negedge clk);
         global_debug_event = 0;
         rd(A_DBG, 32'(s + 1));
      end
      wr(A_LCFG, 32'h8100_1003);
      wait_tok(1);
      `CHK(far_u.got[0], {PAD_ZERO, 1'b1, CT_GREET})
      push(8'hA5);
      push(8'h5C);
      wait_tok(3);
      `CHK(far_u.got[2], 12'h05C)
      `CHK(far_u.min_gap, 3)
      `CHK(far_u.tok_gap >= 4, 1'b1)
      rd(A_LCFG, 32'h8200_1003);
      wr(A_LCFG, 32'hC000_1003);
      push(8'h3C);
      wait_tok(4);
      `CHK(far_u.got[3], 12'h03C)
      far_u.send(12'h05E);
      for (int i = 0; i < 50 && !rx_tok_valid; i++) @(negedge clk);
      `CHK(rx_tok_data, 8'h5E)
      rx_tok_ready = 1;
      far_u.send(12'h17F);
      rd(A_LCFG, 32'hCA00_1003);
      wr(A_LCFG, 32'hC080_1003);
      rd(A_LCFG, 32'hC200_1003);
      wr(A_LCFG, 0);
      rd(A_LCFG, 32'h0200_0000);
      `CHK(link_enable[0], 1'b0)
      for (int i = 0; i < 33; i++) push(8'(i));
      `CHK(tx_in_ready, 1'b0)
      wr(A_LCFG, 32'h8100_0000);
      wait_tok(38);
      `CHK(far_u.got.size(), 37)
      `CHK(far_u.got[36], 12'h01F)
      conclude();
   end
endmodule : tb_srlc_top
